//--- rtl/erb_pkg.sv
package erb_pkg;

   // ****************************************
   // geometry and sizes
   // ****************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int WORDS = 256;
   localparam int WORD_AW = 8;
   localparam int BANK_W = 3;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [11:0] OFF_CFG = 12'h000;
   localparam logic [11:0] OFF_LADDR = 12'h004;
   localparam logic [11:0] OFF_LDATA = 12'h008;
   localparam logic [11:0] OFF_STAT = 12'h00C;

   // ****************************************
   // configuration fields
   // ****************************************
   localparam int CFG_GEOM = 0;
   localparam int CFG_DUAL = 2;
   localparam int CFG_SPLIT = 3;
   localparam int CFG_BYP = 4;
   localparam int CFG_BANK = 10;
   localparam int CFG_CASC = 13;
   localparam int CFG_ROM = 14;
   localparam logic [31:0] CFG_MASK = 32'h0000_7FFF;
   localparam logic [31:0] CFG_RST = 32'h0000_0004;

   // bypass bit positions inside the bypass field
   localparam int BYP_DIN = 0;
   localparam int BYP_DOUT = 1;
   localparam int BYP_WADDR = 2;
   localparam int BYP_WEN = 3;
   localparam int BYP_RADDR = 4;
   localparam int BYP_REN = 5;

   // status fields
   localparam int STAT_WCNT = 0;
   localparam int STAT_LAST = 16;

   typedef enum logic [1:0] {
      GEOM_256X16,
      GEOM_512X8,
      GEOM_1KX4,
      GEOM_2KX2
   } erb_geom_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } erb_wr_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
   } erb_rd_t;

endpackage

//--- rtl/erb_ram_block.sv
// Notes on behaviour
// - geometry selectable: 256x16, 512x8, 1024x4 or 2048x2
// - single-port shares one address; dual-port has separate read and write sections
// - write and read sections run at unrelated rates in dual-port mode
// - each section has its own clock enable freezing only its registers
// - optional scheme: one enable for all inputs, another for output register
// - write is synchronous with an internally timed write strobe
// - each input path can be registered or bypassed independently; the output path is always registered
// - every register clears from local clear or device-wide reset
// - read-only lookup: 8-bit input returns 16-bit result in one access
// - true two-sided dual-port memory needs two instances
// - instances combine for width or cascade by address up to 2048 words
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module erb_ram_block
   import erb_pkg::*;
(
   input logic ref_clk,
   input logic rst_b,
   input logic clr,
   input logic wr_ce,
   input logic rd_ce,
   input logic out_ce,
   input erb_wr_t wr_req,
   input erb_rd_t rd_req,
   output logic [DATA_W-1:0] rd_data,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ****************************************
   // lane helpers
   // ****************************************
   function automatic logic [WORD_AW-1:0] word_of(input logic [1:0] g, input logic [ADDR_W-1:0] a);
      case (g)
         2'd0: word_of = a[7:0];
         2'd1: word_of = a[8:1];
         2'd2: word_of = a[9:2];
         default: word_of = a[10:3];
      endcase
   endfunction

   function automatic logic [3:0] shf_of(input logic [1:0] g, input logic [ADDR_W-1:0] a);
      case (g)
         2'd0: shf_of = 4'h0;
         2'd1: shf_of = {a[0], 3'b000};
         2'd2: shf_of = {a[1:0], 2'b00};
         default: shf_of = {a[2:0], 1'b0};
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] dmask_of(input logic [1:0] g);
      case (g)
         2'd0: dmask_of = 16'hFFFF;
         2'd1: dmask_of = 16'h00FF;
         2'd2: dmask_of = 16'h000F;
         default: dmask_of = 16'h0003;
      endcase
   endfunction

   // cascade: address bits above one block's depth pick the bank
   function automatic logic bank_ok(input logic [1:0] g, input logic [ADDR_W-1:0] a,
                                    input logic [BANK_W-1:0] b, input logic casc);
      if (!casc) begin
         bank_ok = 1'b1;
      end else begin
         case (g)
            2'd0: bank_ok = (a[10:8] == b);
            2'd1: bank_ok = (a[10:9] == b[1:0]);
            2'd2: bank_ok = (a[10] == b[0]);
            default: bank_ok = 1'b1;
         endcase
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [31:0] cfg_r;
   logic [WORD_AW-1:0] laddr_r;
   logic [15:0] wcnt_r;
   logic [ADDR_W-1:0] last_wa_r;
   logic [DATA_W-1:0] mem_r [WORDS];
   logic [ADDR_W-1:0] wa_r;
   logic we_r;
   logic [DATA_W-1:0] din_r;
   logic [ADDR_W-1:0] ra_r;
   logic re_r;
   logic [DATA_W-1:0] rd_data_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // ****************************************
   // configuration decode
   // ****************************************
   wire [1:0] geom_w = cfg_r[CFG_GEOM+:2];
   wire dual_w = cfg_r[CFG_DUAL];
   wire split_w = cfg_r[CFG_SPLIT];
   wire [5:0] byp_w = cfg_r[CFG_BYP+:6];
   wire [BANK_W-1:0] bank_w = cfg_r[CFG_BANK+:BANK_W];
   wire casc_w = cfg_r[CFG_CASC];
   wire rom_w = cfg_r[CFG_ROM];
   wire clr_all = !rst_b || clr;

   // ****************************************
   // clock enables per section
   // ****************************************
   // split scheme: write enable clocks all inputs, out_ce the output
   wire in_rce = split_w ? wr_ce : rd_ce;
   wire oce_w = split_w ? out_ce : rd_ce;

   // ****************************************
   // input registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         wa_r <= 11'h000;
         we_r <= 1'b0;
         din_r <= 16'h0000;
      end else if (wr_ce) begin
         wa_r <= wr_req.addr;
         we_r <= wr_req.en;
         din_r <= wr_req.data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         ra_r <= 11'h000;
         re_r <= 1'b0;
      end else if (in_rce) begin
         ra_r <= rd_req.addr;
         re_r <= rd_req.en;
      end
   end

   // registered or bypassed per path
   wire [ADDR_W-1:0] wa_s = byp_w[BYP_WADDR] ? wr_req.addr : wa_r;
   wire we_s = byp_w[BYP_WEN] ? wr_req.en : we_r;
   wire [DATA_W-1:0] din_s = byp_w[BYP_DIN] ? wr_req.data : din_r;
   wire [ADDR_W-1:0] ra_s = byp_w[BYP_RADDR] ? rd_req.addr : ra_r;
   wire re_s = byp_w[BYP_REN] ? rd_req.en : re_r;

   // ****************************************
   // write section
   // ****************************************
   // one write and one read section per instance; both sides writing
   // at once takes a second instance
   wire wsel = bank_ok(geom_w, wa_s, bank_w, casc_w);
   wire wr_stb = we_s && wr_ce && wsel && !rom_w;
   wire [WORD_AW-1:0] wword = word_of(geom_w, wa_s);
   wire [3:0] wshf = shf_of(geom_w, wa_s);
   wire [DATA_W-1:0] wmask = dmask_of(geom_w) << wshf;
   wire [DATA_W-1:0] wfill = (din_s & dmask_of(geom_w)) << wshf;

   // ****************************************
   // read section
   // ****************************************
   wire [ADDR_W-1:0] ra_eff = dual_w ? ra_s : wa_s;
   wire rsel = bank_ok(geom_w, ra_eff, bank_w, casc_w);
   wire [WORD_AW-1:0] rword = word_of(geom_w, ra_eff);
   wire [3:0] rshf = shf_of(geom_w, ra_eff);
   wire [DATA_W-1:0] rdat = (mem_r[rword] >> rshf) & dmask_of(geom_w);
   wire rd_upd = re_s && (byp_w[BYP_DOUT] ? in_rce : oce_w);

   // ****************************************
   // apb decode
   // ****************************************
   wire hit_cfg = (paddr == OFF_CFG);
   wire hit_laddr = (paddr == OFF_LADDR);
   wire hit_ldata = (paddr == OFF_LDATA);
   wire hit_stat = (paddr == OFF_STAT);
   wire hit_any = hit_cfg || hit_laddr || hit_ldata || hit_stat;
   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pready_r && pwrite;
   wire rom_ld = apb_wr && hit_ldata && rom_w;
   wire [31:0] stat_w = {5'h00, last_wa_r, wcnt_r};
   wire [31:0] rd_mux = hit_cfg ? cfg_r :
                        hit_laddr ? {24'h00_0000, laddr_r} :
                        hit_ldata ? {16'h0000, mem_r[laddr_r]} :
                        hit_stat ? stat_w : 32'h0000_0000;

   // ****************************************
   // memory array
   // ****************************************
   // pattern load only in lookup mode, user writes only outside it
   always_ff @(posedge ref_clk) begin
      if (rom_ld) begin
         mem_r[laddr_r] <= pwdata[DATA_W-1:0];
      end else if (wr_stb) begin
         mem_r[wword] <= (mem_r[wword] & ~wmask) | wfill;
      end
   end

   // ****************************************
   // output register
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         rd_data_r <= 16'h0000;
      end else if (rd_upd) begin
         rd_data_r <= rsel ? rdat : 16'h0000;
      end
   end

   // ****************************************
   // registers and status
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         cfg_r <= CFG_RST;
      end else if (apb_wr && hit_cfg) begin
         cfg_r <= pwdata & CFG_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         laddr_r <= 8'h00;
      end else if (apb_wr && hit_laddr) begin
         laddr_r <= pwdata[WORD_AW-1:0];
      end else if (rom_ld) begin
         laddr_r <= laddr_r + 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         wcnt_r <= 16'h0000;
         last_wa_r <= 11'h000;
      end else if (wr_stb) begin
         wcnt_r <= wcnt_r + 16'h0001;
         last_wa_r <= wa_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr_all) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= apb_setup;
         if (apb_setup) begin
            pslverr_r <= !hit_any;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   assign rd_data = rd_data_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ****************************************
   // checks
   // ****************************************
   chk_geom_narrow: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rd_upd && !clr && geom_w == 2'd3) |=> rd_data_r[15:2] == 14'h0000)
      else $error("narrow geometry read drove upper bits");

   chk_single_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!dual_w && rd_upd && rsel && !clr && !wr_stb && !rom_ld)
      |=> rd_data_r == (($past(mem_r[word_of(geom_w, wa_s)]) >> $past(wshf)) & $past(dmask_of(geom_w))))
      else $error("single-port read did not use write address");

   chk_wr_freeze: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!wr_ce && !clr) |=> ($stable(wa_r) && $stable(we_r) && $stable(din_r)))
      else $error("write section moved without its enable");

   chk_rd_freeze: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!in_rce && !clr) |=> ($stable(ra_r) && $stable(re_r)))
      else $error("read section moved without its enable");

   chk_split_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (split_w && !out_ce && !byp_w[BYP_DOUT] && !clr) |=> $stable(rd_data_r))
      else $error("output register moved without output enable");

   chk_wr_strobe: assert property (@(posedge ref_clk) disable iff (!rst_b)
      wr_stb |=> (mem_r[$past(wword)] & $past(wmask)) == $past(wfill))
      else $error("write strobe did not store data");

   chk_addr_reg: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!byp_w[BYP_WADDR] && wr_ce && !clr) |=> wa_r == $past(wr_req.addr))
      else $error("registered write address not one cycle late");

   chk_clear_all: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clr |=> (rd_data_r == 16'h0000 && !we_r && !re_r && cfg_r == CFG_RST))
      else $error("local clear left a register set");

   chk_rom_nowr: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rom_w && we_s && wr_ce && !rom_ld) |=> mem_r[$past(wword)] == $past(mem_r[wword]))
      else $error("user write reached memory in lookup mode");

   chk_bank_miss: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rd_upd && !rsel && !clr) |=> rd_data_r == 16'h0000)
      else $error("unselected bank drove read data");

   chk_rd_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!rd_upd && !clr) |=> $stable(rd_data_r))
      else $error("read output changed without read");

   chk_byte_narrow: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rd_upd && !clr && geom_w == 2'h1) |=> rd_data_r[15:8] == 8'h00)
      else $error("byte geometry read drove upper bits");

   chk_sect_indep: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (dual_w && !split_w && rd_ce && !wr_ce && !clr) |=> (ra_r == $past(rd_req.addr) && re_r == $past(rd_req.en)))
      else $error("read section stalled by write enable");

   chk_split_in: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (split_w && wr_ce && !clr) |=> (ra_r == $past(rd_req.addr) && re_r == $past(rd_req.en)))
      else $error("read inputs ignored the input enable");

   chk_wr_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (wr_stb && !clr) |=> (wcnt_r == $past(wcnt_r) + 16'h0001 && last_wa_r == $past(wa_s)))
      else $error("write strobe not counted");

   chk_ren_reg: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!byp_w[BYP_REN] && in_rce && !clr) |=> re_r == $past(rd_req.en))
      else $error("registered read enable not one cycle late");

   chk_rom_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      rom_ld |=> mem_r[$past(laddr_r)] == $past(pwdata[DATA_W-1:0]))
      else $error("pattern load did not store data");

   chk_casc_skip: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (casc_w && we_s && wr_ce && !wsel && !clr) |=> $stable(wcnt_r))
      else $error("write to another bank was counted");

   chk_rd_old: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (rd_upd && rsel && wr_stb && wword == rword && !clr)
      |=> rd_data_r == (($past(mem_r[rword]) >> $past(rshf)) & $past(dmask_of(geom_w))))
      else $error("read during write did not return old contents");

endmodule

//--- testbench/erb_user_model.sv
`timescale 1ns/100ps
module erb_user_model
   import erb_pkg::*;
(
   input logic ref_clk,
   input logic [DATA_W-1:0] rd_data,
   output logic clr,
   output logic wr_ce,
   output logic rd_ce,
   output logic out_ce,
   output erb_wr_t wr_req,
   output erb_rd_t rd_req
);
   // ****************************************
   // user logic on the memory ports
   // ****************************************
   initial begin
      clr = 1'b0;
      wr_ce = 1'b1;
      rd_ce = 1'b1;
      out_ce = 1'b1;
      wr_req = '0;
      rd_req = '0;
   end

   // one request per cycle, registered to ref_clk
   task automatic xfer(input logic we, input logic [10:0] wa, input logic [15:0] wd,
                       input logic re, input logic [10:0] ra, input int lat, output logic [15:0] q);
      @(posedge ref_clk);
      wr_req <= '{we, wa, wd};
      rd_req <= '{re, ra};
      @(posedge ref_clk);
      // released address and data lines show the inverse, not the last value; enables go low
      wr_req <= '{1'b0, ~wa, ~wd};
      rd_req <= '{1'b0, ~ra};
      // result taken at the edge after the one that loads it
      repeat (lat) @(posedge ref_clk);
      q = rd_data;
   endtask
endmodule

//--- testbench/erb_ram_block_test.sv
`timescale 1ns/100ps
module erb_ram_block_test
   import erb_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_b, psel, penable, pwrite, pready, pslverr, clr, wr_ce, rd_ce, out_ce, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [DATA_W-1:0] rd_data, q;
   erb_wr_t wr_req;
   erb_rd_t rd_req;
   int n_fail = 0;
   int total_checks = 0;

   always #50 ref_clk = ~ref_clk;

   erb_ram_block u_erb_ram_block (.ref_clk(ref_clk), .rst_b(rst_b), .clr(clr), .wr_ce(wr_ce),
      .rd_ce(rd_ce), .out_ce(out_ce), .wr_req(wr_req), .rd_req(rd_req), .rd_data(rd_data),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   erb_user_model u_erb_user_model (.ref_clk(ref_clk), .rd_data(rd_data), .clr(clr),
      .wr_ce(wr_ce), .rd_ce(rd_ce), .out_ce(out_ce), .wr_req(wr_req), .rd_req(rd_req));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_r(input string nm, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic chk_d(input string nm, input logic [15:0] x);
      chk_r(nm, {16'h0000, x}, {16'h0000, q});
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      u_erb_user_model.xfer(1'b1, a, d, 1'b0, ~a, 1, q);
   endtask

   task automatic rd(input logic [10:0] a, input int lat);
      u_erb_user_model.xfer(1'b0, ~a, 16'h0000, 1'b1, a, lat, q);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      apb(1'b0, OFF_CFG, 32'h0000_0000);
      chk_r("cfg reset", 32'h0000_0004, r);
      q = rd_data;
      chk_d("dout reset", 16'h0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk_r("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
      chk_r("unmapped data", 32'h0000_0000, r);
      apb(1'b1, OFF_CFG, 32'hFFFF_FFFF);
      apb(1'b0, OFF_CFG, 32'h0000_0000);
      chk_r("cfg mask", 32'h0000_7FFF, r);
      apb(1'b1, OFF_CFG, 32'h0000_0004);
      $display("test reset finished");
   endtask

   task automatic t_rw();
      wr(11'h012, 16'h1111);
      u_erb_user_model.xfer(1'b1, 11'h012, 16'h2222, 1'b1, 11'h012, 2, q);
      chk_d("rd during wr", 16'h1111);
      rd(11'h012, 2);
      chk_d("rd after wr", 16'h2222);
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      chk_r("last wr addr", 32'h0012_0000, r & 32'h07FF_0000);
      $display("test rw finished");
   endtask

   task automatic t_ce();
      wr(11'h020, 16'hA5A5);
      rd(11'h020, 2);
      chk_d("rd a5", 16'hA5A5);
      u_erb_user_model.rd_ce <= 1'b0;
      rd(11'h012, 2);
      chk_d("rd frozen", 16'hA5A5);
      u_erb_user_model.rd_ce <= 1'b1;
      u_erb_user_model.wr_ce <= 1'b0;
      wr(11'h020, 16'h5A5A);
      rd(11'h020, 2);
      chk_d("wr frozen", 16'hA5A5);
      u_erb_user_model.wr_ce <= 1'b1;
      u_erb_user_model.xfer(1'b0, 11'h000, 16'h0000, 1'b0, 11'h012, 2, q);
      chk_d("rd en low", 16'hA5A5);
      $display("test ce finished");
   endtask

   task automatic t_geom();
      for (int g = 1; g < 4; g++) begin
         apb(1'b1, OFF_CFG, 32'h0000_0004 | 32'(g));
         wr(11'h040 + 11'(g), 16'hFFFF);
         rd(11'h040 + 11'(g), 2);
         chk_d("geom width", 16'hFFFF >> (16 - (16 >> g)));
      end
      apb(1'b1, OFF_CFG, 32'h0000_03F4);
      wr(11'h050, 16'h0BAD);
      rd(11'h050, 1);
      chk_d("bypassed", 16'h0BAD);
      $display("test geom finished");
   endtask

   task automatic t_split();
      apb(1'b1, OFF_CFG, 32'h0000_000C);
      u_erb_user_model.rd_ce <= 1'b0;
      rd(11'h012, 2);
      chk_d("split rd", 16'h2222);
      u_erb_user_model.out_ce <= 1'b0;
      rd(11'h050, 2);
      chk_d("split hold", 16'h2222);
      u_erb_user_model.out_ce <= 1'b1;
      u_erb_user_model.rd_ce <= 1'b1;
      apb(1'b1, OFF_CFG, 32'h0000_0000);
      wr(11'h060, 16'h6060);
      u_erb_user_model.xfer(1'b0, 11'h060, 16'h0000, 1'b1, 11'h012, 2, q);
      chk_d("single port", 16'h6060);
      $display("test split finished");
   endtask

   task automatic t_rom();
      apb(1'b1, OFF_CFG, 32'h0000_4004);
      apb(1'b1, OFF_LADDR, 32'h0000_0010);
      apb(1'b1, OFF_LDATA, 32'h0000_BEEF);
      apb(1'b0, OFF_LADDR, 32'h0000_0000);
      chk_r("load ptr", 32'h0000_0011, r);
      wr(11'h010, 16'h1234);
      rd(11'h010, 2);
      chk_d("lookup", 16'hBEEF);
      apb(1'b1, OFF_CFG, 32'h0000_2404);
      wr(11'h105, 16'hCAFE);
      rd(11'h105, 2);
      chk_d("bank hit", 16'hCAFE);
      rd(11'h005, 2);
      chk_d("bank miss", 16'h0000);
      wr(11'h005, 16'h1111);
      rd(11'h105, 2);
      chk_d("bank skip", 16'hCAFE);
      $display("test rom finished");
   endtask

   task automatic t_clr();
      apb(1'b1, OFF_CFG, 32'h0000_0007);
      rd(11'h090, 2);
      chk_d("narrow rd", 16'h0002);
      u_erb_user_model.clr <= 1'b1;
      @(posedge ref_clk);
      u_erb_user_model.clr <= 1'b0;
      @(posedge ref_clk);
      q = rd_data;
      chk_d("clr dout", 16'h0000);
      apb(1'b0, OFF_CFG, 32'h0000_0000);
      chk_r("clr cfg", 32'h0000_0004, r);
      $display("test clr finished");
   endtask

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_rw();
      t_ce();
      t_geom();
      t_split();
      t_rom();
      t_clr();
      give_verdict();
   end
endmodule
